/* log_pack_pkg.sv */
/*
 Constants for the sensor log record packer: register offsets, control
 and status field positions, reset values and memory bounds.
 Assumes a 32-bit APB register bus and an 8-bit block address space.
*/
package log_pack_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OUTBAND = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_TEMP_ON = 4;
  localparam int CTRL_X_ON = 5;
  localparam int CTRL_Y_ON = 6;
  localparam int CTRL_IRQ_MODE = 7;
  localparam int CTRL_IRQ_MIN = 8;
  // Config register fields
  localparam int CFG_IRQ_SIZE = 0;
  localparam int CFG_LAST = 8;
  localparam int CFG_MINUTES = 16;
  // Status register fields
  localparam int ST_COUNT = 0;
  localparam int ST_TICK = 8;
  localparam int ST_ACTIVE = 16;
  localparam int ST_OVERFLOW = 17;
  localparam int ST_STARTED = 18;
  localparam int ST_OUTBAND = 19;
  localparam int ST_ALARM = 20;
  localparam int ST_IRQ_CNT = 24;
  localparam logic [8:0] CTRL_RESET = 9'h010;
  localparam logic [23:0] CFG_RESET = 24'h01_FF_04;
  // Base block of the logging region and top block of the address space
  localparam logic [7:0] LOG_BASE = 8'h1C;
  localparam logic [7:0] BLOCK_TOP = 8'hFF;
endpackage

/* sensor_log_record_packer.sv */
/*
 Sensor log record packer: packs temperature, X, Y and tick bytes into
 32-bit blocks of the logging region, writes interrupt records, and
 polices radio-side access to the logging bank.
 Assumes an APB master, one sample strobe from the monitor engine, and
 a block write port into the nonvolatile array that accepts every
 strobe. Radio requests are decided one per cycle.
*/
// Overview of operation
// - Radio may only read logging bank blocks
// - Monitor always writes logging bank freely
// - Interrupt records start at block 1Ch
// - Record byte two holds interval minutes
// - Track X and Y extremes every phase
// - Data blocks run from area end to last
// - Keep 8-bit count of data blocks written
// - Temp only: four temps, oldest lowest
// - Temp and X: temp, X pairs
// - Temp, X, Y per block, top reserved
// - X only: four X, oldest lowest
// - X and Y: X, Y pairs
// - Outband temp only: temp, tick pairs
// - Outband with X/Y: temp, tick, X, Y
// - Tick counter counts every temp measurement
// - Tick stored only with a temperature
// - Tick overflow forces a zero-tick record
// - Reset clears count, flags and alarm
// - User region spans last plus one to FFh
// - Start clears the measurement count
// - Writing the last block stops logging
// - Outband bit selects limit-based logging only while temp is on
`timescale 1ns/1ps
module sensor_log_record_packer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic [7:0] temp_sample,
  input wire logic [7:0] x_sample,
  input wire logic [7:0] y_sample,
  input wire logic out_of_limit,
  input wire logic irq_sample,
  input wire logic irq_end,
  input wire logic rf_req,
  input wire logic rf_we,
  input wire logic [7:0] rf_addr,
  output logic rf_grant,
  output logic rf_reject,
  output logic rf_user,
  output logic mem_wr,
  output logic [7:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic limit_alarm_output
);
  logic [8:0] ctrl;
  logic [23:0] cfg;
  logic active, started, overflow;
  logic [7:0] measurement_count, measurement_tick_count, irq_cnt;
  logic [7:0] data_ptr, irq_extreme_x, irq_extreme_y;
  logic [31:0] stage;
  logic [1:0] slot;
  logic irq_seen;

  wire logic [7:0] irq_area_size = cfg[log_pack_pkg::CFG_IRQ_SIZE +: 8];
  wire logic [7:0] log_area_last_block = cfg[log_pack_pkg::CFG_LAST +: 8];
  wire logic [7:0] interval_minutes = cfg[log_pack_pkg::CFG_MINUTES +: 8];
  wire logic temperature_log_policy = ctrl[log_pack_pkg::CTRL_OUTBAND];
  wire logic temp_sensor_on = ctrl[log_pack_pkg::CTRL_TEMP_ON];
  wire logic port_x_on = ctrl[log_pack_pkg::CTRL_X_ON];
  wire logic port_y_on = ctrl[log_pack_pkg::CTRL_Y_ON];
  wire logic irq_mode = ctrl[log_pack_pkg::CTRL_IRQ_MODE];
  wire logic track_min = ctrl[log_pack_pkg::CTRL_IRQ_MIN];

  // APB decode; the answer comes one cycle into the access phase
  wire logic apb_acc = psel & penable & ~pready;
  wire logic hit_ctrl = paddr == log_pack_pkg::REG_CTRL;
  wire logic hit_cfg = paddr == log_pack_pkg::REG_CFG;
  wire logic hit_stat = paddr == log_pack_pkg::REG_STATUS;
  wire logic mapped = hit_ctrl | hit_cfg | hit_stat;
  wire logic wr_ctrl = apb_acc & pwrite & hit_ctrl;
  wire logic wr_cfg = apb_acc & pwrite & hit_cfg;
  wire logic start_cmd = wr_ctrl & pwdata[log_pack_pkg::CTRL_START];
  wire logic stop_cmd = wr_ctrl & pwdata[log_pack_pkg::CTRL_STOP];
  wire logic [31:0] status_word = {irq_cnt, 3'h0, limit_alarm_output,
    temperature_log_policy, started, overflow, active,
    measurement_tick_count, measurement_count};
  wire logic [31:0] next_prdata = hit_ctrl ? {23'h0, ctrl} :
    hit_cfg ? {8'h00, cfg} : hit_stat ? status_word : 32'h0000_0000;

  // Radio side: the logging bank is read-only whatever the locks say
  wire logic in_log = rf_addr >= log_pack_pkg::LOG_BASE &&
    rf_addr <= log_area_last_block;
  wire logic in_user = rf_addr > log_area_last_block &&
    rf_addr <= log_pack_pkg::BLOCK_TOP;

  // Measurement packing
  wire logic temp_meas = active & sample_valid & temp_sensor_on;
  wire logic [7:0] next_tick = measurement_tick_count + 8'h01;
  wire logic tick_wrap = next_tick == 8'h00;
  wire logic outband = temperature_log_policy & temp_sensor_on;
  wire logic temp_only = temp_sensor_on & ((~port_x_on & ~port_y_on) |
    irq_mode);
  wire logic keep = active & sample_valid &
    (~outband | out_of_limit | tick_wrap);
  logic [31:0] pack;
  logic [2:0] width;
  always_comb
  begin
    pack = {24'h00_0000, temp_sample};
    width = 3'd1;
    if (outband & temp_only)
    begin
      pack = {16'h0000, next_tick, temp_sample};
      width = 3'd2;
    end
    else if (outband)
    begin
      pack = {y_sample, x_sample, next_tick, temp_sample};
      width = 3'd4;
    end
    else if (temp_only)
    begin
      pack = {24'h00_0000, temp_sample};
      width = 3'd1;
    end
    else if (temp_sensor_on & port_x_on & ~port_y_on)
    begin
      pack = {16'h0000, x_sample, temp_sample};
      width = 3'd2;
    end
    else if (temp_sensor_on)
    begin
      pack = {8'h00, y_sample, x_sample, temp_sample};
      width = 3'd4;
    end
    else if (port_x_on & ~port_y_on)
    begin
      pack = {24'h00_0000, x_sample};
      width = 3'd1;
    end
    else if (port_x_on)
    begin
      pack = {16'h0000, y_sample, x_sample};
      width = 3'd2;
    end
    else
    begin
      pack = {24'h00_0000, y_sample};
      width = 3'd1;
    end
  end
  wire logic [31:0] merged = stage | (pack << {slot, 3'b000});
  wire logic [2:0] filled = {1'b0, slot} + width;
  wire logic block_done = keep & filled[2];
  wire logic last_write = block_done & (data_ptr == log_area_last_block);
  wire logic [7:0] data_first = log_pack_pkg::LOG_BASE + irq_area_size;
  wire logic irq_room = irq_cnt < irq_area_size;
  wire logic irq_write = irq_end & irq_seen & irq_room & ~block_done;
  wire logic [7:0] next_ex = (track_min ^ (x_sample > irq_extreme_x)) |
    ~irq_seen ? x_sample : irq_extreme_x;
  wire logic [7:0] next_ey = (track_min ^ (y_sample > irq_extreme_y)) |
    ~irq_seen ? y_sample : irq_extreme_y;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      ctrl <= log_pack_pkg::CTRL_RESET;
      cfg <= log_pack_pkg::CFG_RESET;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~mapped;
      prdata <= apb_acc & ~pwrite ? next_prdata : 32'h0000_0000;
      if (wr_ctrl)
        ctrl <= pwdata[8:0] & 9'h1F2;
      if (wr_cfg)
        cfg <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rf_grant <= 1'b0;
      rf_reject <= 1'b0;
      rf_user <= 1'b0;
    end
    else
    begin
      rf_grant <= rf_req & ~(rf_we & in_log);
      rf_reject <= rf_req & rf_we & in_log;
      rf_user <= rf_req & in_user;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active <= 1'b0;
      started <= 1'b0;
      overflow <= 1'b0;
      measurement_count <= 8'h00;
      measurement_tick_count <= 8'h00;
      limit_alarm_output <= 1'b0;
    end
    else if (start_cmd)
    begin
      active <= 1'b1;
      started <= 1'b1;
      overflow <= 1'b0;
      measurement_count <= 8'h00;
      measurement_tick_count <= 8'h00;
      limit_alarm_output <= 1'b0;
    end
    else
    begin
      if (stop_cmd | last_write)
        active <= 1'b0;
      if (last_write)
        overflow <= 1'b1;
      if (block_done)
        measurement_count <= measurement_count + 8'h01;
      if (temp_meas)
        measurement_tick_count <= next_tick;
      if (active & sample_valid & outband & out_of_limit)
        limit_alarm_output <= 1'b1;
    end
  end

  // Staging keeps partial blocks so the array sees whole words only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage <= 32'h0000_0000;
      slot <= 2'b00;
      data_ptr <= log_pack_pkg::LOG_BASE;
      mem_wr <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 32'h0000_0000;
    end
    else
    begin
      mem_wr <= block_done | irq_write;
      if (start_cmd)
      begin
        stage <= 32'h0000_0000;
        slot <= 2'b00;
        data_ptr <= data_first;
      end
      else if (block_done)
      begin
        stage <= 32'h0000_0000;
        slot <= 2'b00;
        data_ptr <= data_ptr + 8'h01;
        mem_addr <= data_ptr;
        mem_wdata <= merged;
      end
      else if (keep)
      begin
        stage <= merged;
        slot <= filled[1:0];
      end
      if (irq_write)
      begin
        mem_addr <= log_pack_pkg::LOG_BASE + irq_cnt;
        mem_wdata <= {measurement_count, interval_minutes,
          irq_extreme_y, irq_extreme_x};
      end
    end
  end

  // A record that collides with a data block waits for the next irq_end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_cnt <= 8'h00;
      irq_seen <= 1'b0;
      irq_extreme_x <= 8'h00;
      irq_extreme_y <= 8'h00;
    end
    else if (start_cmd)
    begin
      irq_cnt <= 8'h00;
      irq_seen <= 1'b0;
    end
    else
    begin
      if (irq_write | (irq_end & ~irq_room))
        irq_seen <= 1'b0;
      else if (active & irq_sample)
        irq_seen <= 1'b1;
      if (irq_write)
        irq_cnt <= irq_cnt + 8'h01;
      if (active & irq_sample)
      begin
        irq_extreme_x <= next_ex;
        irq_extreme_y <= next_ey;
      end
    end
  end

  sequence s_apb_req;
    psel & penable & ~pready;
  endsequence
  sequence s_apb_ans;
    ##1 pready ##1 ~pready;
  endsequence

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_req |-> s_apb_ans)
    else $error("APB answer not one cycle wide");
  a_rf_write_blocked: assert property (@(posedge pclk)
    disable iff (!presetn)
    rf_req & rf_we & in_log |=> rf_reject & ~rf_grant)
    else $error("Radio write to logging bank granted");
  a_rf_read_ok: assert property (@(posedge pclk)
    disable iff (!presetn)
    rf_req & ~rf_we |=> rf_grant & ~rf_reject)
    else $error("Radio read refused");
  a_count_start: assert property (@(posedge pclk)
    disable iff (!presetn)
    start_cmd |=> measurement_count == 8'h00 && active)
    else $error("Start did not clear count");
  a_count_step: assert property (@(posedge pclk)
    disable iff (!presetn)
    block_done & ~start_cmd |=>
      measurement_count == $past(measurement_count) + 8'h01 && mem_wr)
    else $error("Block write did not advance count");
  a_last_stops: assert property (@(posedge pclk)
    disable iff (!presetn)
    last_write & ~start_cmd |=> ~active && overflow && mem_wr)
    else $error("Last block did not stop logging");
  a_tick_step: assert property (@(posedge pclk)
    disable iff (!presetn)
    temp_meas & ~start_cmd |=>
      measurement_tick_count == $past(measurement_tick_count) + 8'h01)
    else $error("Tick counter missed a measurement");
  a_wrap_kept: assert property (@(posedge pclk)
    disable iff (!presetn)
    active & sample_valid & outband & temp_only & tick_wrap &
      slot == 2'b10 & ~start_cmd |=> mem_wr && mem_wdata[31:24] == 8'h00)
    else $error("Tick wrap record not stored");
  a_irq_record: assert property (@(posedge pclk)
    disable iff (!presetn)
    irq_write & ~start_cmd |=> mem_wr &&
      mem_addr == log_pack_pkg::LOG_BASE + $past(irq_cnt) &&
      mem_wdata[23:16] == interval_minutes)
    else $error("Interrupt record misplaced");
  a_temp_pack: assert property (@(posedge pclk)
    disable iff (!presetn)
    keep & block_done & ~outband & temp_only & ~start_cmd |=>
      mem_wdata[31:24] == $past(temp_sample))
    else $error("Newest temperature not in top byte");
  a_data_floor: assert property (@(posedge pclk)
    disable iff (!presetn)
    mem_wr & ~$past(irq_write) |->
      mem_addr >= log_pack_pkg::LOG_BASE + irq_area_size)
    else $error("Data block written into record area");
endmodule // sensor_log_record_packer

/* nv_array_model.sv */
/*
 Nonvolatile array model standing behind the packer's block write port.
 Assumes single-cycle write strobes; it never stalls the packer.
*/
`timescale 1ns/1ps
module nv_array_model (
  input wire logic pclk,
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output int writes,
  output logic [7:0] last_addr,
  output logic [31:0] last_data
);
  // Accepts every strobe, so monitor writes are never refused
  always @(posedge pclk)
    if (mem_wr === 1'b1)
    begin
      last_addr <= mem_addr;
      last_data <= mem_wdata;
      writes <= writes + 1;
    end
endmodule // nv_array_model

/* test_sensor_log_record_packer.sv */
/*
 Self-checking bench for the sensor log record packer: registers over
 APB, radio access policing, block packing and interrupt records.
 Assumes nv_array_model as the array behind the write port.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("BAD %s exp %h got %h", n, e, g); \
    end \
  end
module test_sensor_log_record_packer;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, rf_addr = 8'h00, mem_addr, last_addr;
  logic [31:0] pwdata = 32'h0, prdata, rd, mem_wdata, last_data;
  logic pready, pslverr, err, sample_valid = 0, out_of_limit = 0;
  logic irq_sample = 0, irq_end = 0, rf_req = 0, rf_we = 0;
  logic [7:0] temp_sample = 8'h00, x_sample = 8'h00, y_sample = 8'h00;
  logic rf_grant, rf_reject, rf_user, mem_wr, limit_alarm_output;
  int fail_count = 0, comparisons = 0, seen = 0, writes, cycles = 0;
  always #5 pclk = ~pclk;
  sensor_log_record_packer sensor_log_record_packer_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid),
    .temp_sample(temp_sample), .x_sample(x_sample), .y_sample(y_sample),
    .out_of_limit(out_of_limit), .irq_sample(irq_sample),
    .irq_end(irq_end), .rf_req(rf_req), .rf_we(rf_we), .rf_addr(rf_addr),
    .rf_grant(rf_grant), .rf_reject(rf_reject), .rf_user(rf_user),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .limit_alarm_output(limit_alarm_output));
  nv_array_model nv_array_model_inst (.pclk(pclk), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .writes(writes),
    .last_addr(last_addr), .last_data(last_data));
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, log_pack_pkg::REG_CTRL, d);
  endtask
  task automatic st;
    apb(1'b0, log_pack_pkg::REG_STATUS, 32'h0);
  endtask
  task automatic samp(input logic [7:0] t, x, y, input logic o);
    @(posedge pclk);
    sample_valid <= 1'b1;
    temp_sample <= t;
    x_sample <= x;
    y_sample <= y;
    out_of_limit <= o;
    @(posedge pclk);
    sample_valid <= 1'b0;
  endtask
  task automatic irq(input logic [7:0] x, y, input logic e);
    @(posedge pclk);
    irq_sample <= ~e;
    irq_end <= e;
    x_sample <= x;
    y_sample <= y;
    @(posedge pclk);
    irq_sample <= 1'b0;
    irq_end <= 1'b0;
  endtask
  // Bounded wait for one array write, then address and word together
  task automatic blk(input logic [7:0] a, input logic [31:0] d);
    repeat (6)
      if (writes == seen)
        @(posedge pclk);
    `CHK("block", {1'b1, a, d}, {writes > seen, last_addr, last_data})
    seen = writes;
  endtask
  task automatic none;
    repeat (6) @(posedge pclk);
    `CHK("no write", seen, writes)
  endtask
  task automatic rf(input logic w, input logic [7:0] a,
    input logic [2:0] e);
    @(posedge pclk);
    rf_req <= 1'b1;
    rf_we <= w;
    rf_addr <= a;
    @(posedge pclk);
    rf_req <= 1'b0;
    @(posedge pclk);
    `CHK("radio", e, {rf_grant, rf_reject, rf_user})
  endtask
  task automatic reset_values;
    apb(1'b0, log_pack_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000010, rd)
    apb(1'b0, log_pack_pkg::REG_CFG, 32'h0);
    `CHK("cfg", 32'h0001FF04, rd)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic layout_modes;
    logic [31:0] c [6] = '{32'h11, 32'h31, 32'h71, 32'h21, 32'h61,
      32'h41};
    int k [6] = '{4, 2, 1, 4, 2, 4};
    logic [31:0] e [6] = '{32'h13121110, 32'h41114010, 32'h00804010,
      32'h43424140, 32'h81418040, 32'h83828180};
    for (int m = 0; m < 6; m++)
    begin
      ctl(c[m]);
      for (int i = 0; i < k[m]; i++)
        samp(8'h10 + i[7:0], 8'h40 + i[7:0], 8'h80 + i[7:0], 1'b0);
      blk(8'h20, e[m]);
      st;
      `CHK("count", 8'h01, rd[7:0])
    end
  endtask
  task automatic outband;
    ctl(32'h13);
    samp(8'h21, 8'h00, 8'h00, 1'b1);
    samp(8'h22, 8'h00, 8'h00, 1'b0);
    samp(8'h23, 8'h00, 8'h00, 1'b1);
    blk(8'h20, 32'h03230121);
    `CHK("alarm", 1'b1, limit_alarm_output)
    ctl(32'h73);
    samp(8'h31, 8'h41, 8'h81, 1'b1);
    blk(8'h20, 32'h81410131);
    samp(8'h32, 8'h42, 8'h82, 1'b0);
    none;
    // Stop without start: a full-width sample must not reach the array
    ctl(32'h76);
    samp(8'h33, 8'h43, 8'h83, 1'b1);
    none;
    st;
    `CHK("stopped", 1'b0, rd[16])
  endtask
  task automatic tick_wrap;
    ctl(32'h13);
    // Wrap lands in the upper half so the forced record closes a block
    repeat (254) samp(8'h50, 8'h00, 8'h00, 1'b0);
    none;
    samp(8'h51, 8'h00, 8'h00, 1'b1);
    samp(8'h52, 8'h00, 8'h00, 1'b0);
    blk(8'h20, 32'h0052FF51);
  endtask
  task automatic reset_again;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("alarm", 1'b0, limit_alarm_output)
    presetn <= 1'b1;
    st;
    `CHK("status", 32'h0, rd)
  endtask
  task automatic irq_records;
    apb(1'b1, log_pack_pkg::REG_CFG, 32'h0005FF02);
    ctl(32'h91);
    irq(8'h0A, 8'h32, 1'b0);
    irq(8'h1E, 8'h28, 1'b0);
    irq(8'h14, 8'h2D, 1'b0);
    irq(8'h00, 8'h00, 1'b1);
    blk(8'h1C, 32'h0005321E);
    irq(8'h07, 8'h09, 1'b0);
    irq(8'h00, 8'h00, 1'b1);
    blk(8'h1D, 32'h00050907);
    irq(8'h00, 8'h00, 1'b1);
    none;
    for (int i = 0; i < 4; i++)
      samp(8'h90 + i[7:0], 8'h00, 8'h00, 1'b0);
    blk(8'h1E, 32'h93929190);
  endtask
  task automatic last_block;
    apb(1'b1, log_pack_pkg::REG_CFG, 32'h00012104);
    // Capture mode tracking minima; data still packs as temp only
    ctl(32'h191);
    irq(8'h0A, 8'h32, 1'b0);
    irq(8'h05, 8'h40, 1'b0);
    irq(8'h00, 8'h00, 1'b1);
    blk(8'h1C, 32'h00013205);
    for (int b = 0; b < 2; b++)
    begin
      for (int i = 0; i < 4; i++)
        samp(8'h60 + i[7:0], 8'h00, 8'h00, 1'b0);
      blk(8'h20 + b[7:0], 32'h63626160);
    end
    st;
    `CHK("stop", 10'h202, {rd[17:16], rd[7:0]})
    repeat (4) samp(8'h70, 8'h00, 8'h00, 1'b0);
    none;
    rf(1'b1, 8'h1C, 3'b010);
    rf(1'b0, 8'h21, 3'b100);
    rf(1'b1, 8'h21, 3'b010);
    rf(1'b1, 8'h22, 3'b101);
    rf(1'b1, 8'h1B, 3'b100);
  endtask
  task automatic summarize;
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    reset_values;
    layout_modes;
    outband;
    tick_wrap;
    reset_again;
    irq_records;
    last_block;
    summarize;
  end
  // Whole run needs under a thousand cycles; this only cuts a hang
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize;
    end
  end
endmodule // test_sensor_log_record_packer
